/* ddr3_write_leveling_bench.sv */
// bench for the write leveling sequencer against a memory rank model
`timescale 1ns/1ps
`default_nettype none
module ddr3_write_leveling_bench import wl_pkg::*;;
  typedef struct packed {
    logic [1:0] rank;
    logic qoff;
    logic down;
    logic stuck;
    logic [15:0] exit_mr1;
  } row_t;
  localparam row_t ROWS [4] = '{'{2'h0, 1'b0, 1'b0, 1'b0, 16'hffff},
    '{2'h1, 1'b1, 1'b0, 1'b1, 16'h1a66}, '{2'h0, 1'b1, 1'b1, 1'b1, 16'h0080},
    '{2'h1, 1'b0, 1'b0, 1'b0, 16'h2a5a}};
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  logic qoff = 1'b0;
  logic step_down = 1'b0;
  logic stuck = 1'b0;
  logic [1:0] target_rank = 2'h0;
  logic [15:0] exit_mr1 = 16'h0000;
  logic busy, done, locked, fail, ck, odt, dqs, dqs_n, dqs_oe, lvl;
  logic [5:0] dqs_delay, smp_tap;
  logic [7:0] dq;
  logic [15:0] mr1, ent_mr1;
  logic [1:0] smp;
  cmd_t cmd;
  int viol, error_cnt, n_checks, cyc, n_done;
  real t_exit, t_done;
  // strobe high time and pulse gap keep their package defaults
  wl_ctrl #(.MOD_C(3), .MRD_C(2), .WLDQSEN_C(2), .PRE_C(2),
    .ODT_OFF_C(2)) u_dut (.clk(clk), .rst_b(rst_b), .start(start),
    .target_rank(target_rank), .qoff(qoff), .step_down(step_down), .exit_mr1(exit_mr1),
    .busy(busy), .done(done), .locked(locked), .fail(fail), .dqs_delay(dqs_delay),
    .ck(ck), .cmd(cmd), .odt(odt), .dqs(dqs), .dqs_n(dqs_n), .dqs_oe(dqs_oe), .dq(dq));
  wl_dram_model u_mem (.ck(ck), .cmd(cmd), .odt(odt), .dqs(dqs), .dqs_oe(dqs_oe),
    .tap(dqs_delay), .rank(target_rank), .stuck(stuck), .dq(dq), .lvl(lvl), .mr1(mr1),
    .ent_mr1(ent_mr1), .smp(smp), .smp_tap(smp_tap), .viol(viol), .t_exit(t_exit));
  // clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (done === 1'b1) n_done++;
    if (cyc == 40000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check_idle();
    check(cmd, CMD_NOP);
    check({ck, odt, dqs_oe, dqs, dqs_n, busy, locked, fail, done}, 9'h010);
    check(dqs_delay, 6'h00);
  endtask
  // one whole leveling run with a stray start in the middle
  task automatic run(input row_t r);
    int k;
    target_rank = r.rank;
    qoff = r.qoff;
    step_down = r.down;
    stuck = r.stuck;
    exit_mr1 = r.exit_mr1;
    start = 1'b1;
    n_done = 0;
    for (k = 0; k < 10 && busy !== 1'b1; k++) @(posedge clk);
    #2 start = 1'b0;
    repeat (40) @(posedge clk);
    #2 start = 1'b1;
    repeat (2) @(posedge clk);
    #2 start = 1'b0;
    for (k = 0; k < 9000 && done !== 1'b1; k++) @(posedge clk);
    t_done = $realtime;
    repeat (3) @(posedge clk);
    #2;
    check(n_done, 1);
    check(busy, 1'b0);
    check(t_done - t_exit >= 75.0, 1'b1);
    check({locked, fail}, {!r.stuck, r.stuck});
    if (r.stuck) check(dqs_delay, r.down ? 6'h00 : 6'h3f);
    else check({smp, dqs_delay}, {2'h1, smp_tap});
    check({ent_mr1[MR1_QOFF_BIT], ent_mr1[MR1_WL_BIT]}, {r.qoff, 1'b1});
    check(mr1, r.exit_mr1 & MR1_EXIT_MASK);
    check(lvl, 1'b0);
    check(viol, 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    #2;
    check_idle();
    rst_b = 1'b1;
    foreach (ROWS[i]) run(ROWS[i]);
    start = 1'b1;
    repeat (60) @(posedge clk);
    #2 rst_b = 1'b0;
    #1;
    check_idle();
    test_done();
  end
endmodule
`default_nettype wire

/* wl_ctrl.sv */
// write leveling sequencer driving one memory rank through its pins
`timescale 1ns/1ps
`default_nettype none
module wl_ctrl import wl_pkg::*; #(
  parameter int DQ_W = 8,
  parameter int TAP_W = 6,
  parameter int RANKS = 2,
  parameter int MOD_C = MOD_CYC,
  parameter int MRD_C = MRD_CYC,
  parameter int WLDQSEN_C = WLDQSEN_CYC,
  parameter int PRE_C = (WLMRD_CYC > DQSL_CYC) ? WLMRD_CYC : DQSL_CYC,
  parameter int DQSH_C = DQSH_CYC,
  parameter int WLO_C = WLO_CYC,
  parameter int GAP_C = GAP_CYC,
  parameter int ODT_OFF_C = ODT_OFF_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  // user side
  input wire logic start,
  input wire logic [1:0] target_rank,
  input wire logic qoff,
  input wire logic step_down,
  input wire logic [15:0] exit_mr1,
  output logic busy,
  output logic done,
  output logic locked,
  output logic fail,
  output logic [TAP_W-1:0] dqs_delay,
  // memory side
  output logic ck,
  output cmd_t cmd,
  output logic odt,
  output logic dqs,
  output logic dqs_n,
  output logic dqs_oe,
  input wire logic [DQ_W-1:0] dq
);
  wl_state_t state, next_state;
  logic [15:0] wait_cnt, next_wait;
  logic [DQ_W-1:0] dq_s;
  logic fb_prev, fb_seen, wl_on, do_lock, do_step, tap_end;
  logic [15:0] since_mrs, since_odt;
  logic fb_now;
  logic adv;

  ////////////////////////////////////////////////////////////////////////////
  // feedback path: prime bit after two flops, no read strobe needed
  wl_sync #(.W(DQ_W)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .din(dq),
    .dout(dq_s)
  );
  assign fb_now = dq_s[0];

  // memory clock from a divide by two
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ck <= 1'b0;
    end else begin
      ck <= ~ck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: steps only when its wait is spent and ck is high
  assign adv = (wait_cnt == 16'h0000) && ck;
  assign tap_end = step_down ? (dqs_delay == '0) : (dqs_delay == '1);
  assign do_lock = (state == S_SAMPLE) && adv && fb_seen && !fb_prev && fb_now;
  assign do_step = (state == S_SAMPLE) && adv && !do_lock && !tap_end;

  always_comb begin
    next_state = state;
    next_wait = 16'h0000;
    if (adv) begin
      case (state)
        S_IDLE: begin
          if (start) begin
            next_state = (RANKS > 1) ? S_OTHERS : S_ENTER;
            next_wait = 16'(MRD_C);
          end
        end
        S_OTHERS: begin
          next_state = S_ENTER;
          next_wait = 16'(MOD_C);
        end
        S_ENTER: begin
          next_state = S_ODT_ON;
          next_wait = 16'(WLDQSEN_C);
        end
        S_ODT_ON: begin
          next_state = S_PRE;
          next_wait = 16'(PRE_C);
        end
        S_PRE: begin
          next_state = S_HIGH;
          next_wait = 16'(DQSH_C);
        end
        S_HIGH: begin
          next_state = S_LOW;
          next_wait = 16'(WLO_C);
        end
        S_LOW: begin
          next_state = S_SAMPLE;
        end
        S_SAMPLE: begin
          if (do_step) begin
            next_state = S_PRE;
            next_wait = 16'(GAP_C);
          end else begin
            next_state = S_STOP;
          end
        end
        S_STOP: begin
          next_state = S_ODT_OFF;
          next_wait = 16'(ODT_OFF_C);
        end
        S_ODT_OFF: begin
          next_state = S_EXIT;
          next_wait = 16'(MRD_C);
        end
        S_EXIT: begin
          next_state = S_SETTLE;
          next_wait = 16'(MOD_C - MRD_C);
        end
        S_SETTLE: begin
          next_state = S_IDLE;
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  // state and wait counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      wait_cnt <= 16'h0000;
    end else if (next_state != state) begin
      state <= next_state;
      wait_cnt <= next_wait;
    end else if (wait_cnt != 16'h0000) begin
      wait_cnt <= wait_cnt - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command bus: mode register writes on entering S_OTHERS, S_ENTER and S_EXIT, nop otherwise
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= CMD_NOP;
    end else if (next_state != state && next_state == S_OTHERS) begin
      cmd <= '{cs_n: CS_IDLE ^ ~(4'h1 << target_rank), ras_n: 1'b0, cas_n: 1'b0,
               we_n: 1'b0, ba: 3'(MR1_BA), addr: 16'(1) << MR1_QOFF_BIT};
    end else if (next_state != state && next_state == S_ENTER) begin
      cmd <= '{cs_n: CS_IDLE ^ (4'h1 << target_rank), ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0,
               ba: 3'(MR1_BA),
               addr: (16'(1) << MR1_WL_BIT) | (16'(qoff) << MR1_QOFF_BIT)};
    end else if (next_state != state && next_state == S_EXIT) begin
      cmd <= '{cs_n: CS_IDLE ^ (4'h1 << target_rank), ras_n: 1'b0, cas_n: 1'b0, we_n: 1'b0,
               ba: 3'(MR1_BA), addr: exit_mr1 & MR1_EXIT_MASK};
    end else if (ck) begin
      cmd <= CMD_NOP;
    end
  end

  // termination and strobe pins
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      odt <= 1'b0;
      dqs <= 1'b0;
      dqs_n <= 1'b1;
      dqs_oe <= 1'b0;
    end else begin
      odt <= (next_state >= S_ODT_ON) && (next_state <= S_STOP);
      dqs_oe <= (next_state >= S_PRE) && (next_state <= S_SAMPLE);
      dqs <= (next_state == S_HIGH);
      dqs_n <= (next_state != S_HIGH);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // feedback history: first sample after entry only seeds the history
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fb_prev <= 1'b0;
      fb_seen <= 1'b0;
    end else if (state == S_ENTER) begin
      fb_seen <= 1'b0;
    end else if (state == S_SAMPLE && adv) begin
      fb_prev <= fb_now;
      fb_seen <= 1'b1;
    end
  end

  // delay tap sweep and result flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dqs_delay <= '0;
      locked <= 1'b0;
      fail <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else begin
      busy <= (next_state != S_IDLE);
      done <= (state == S_SETTLE) && adv;
      if (state == S_IDLE && adv && start) begin
        locked <= 1'b0;
        fail <= 1'b0;
      end else if (do_lock) begin
        locked <= 1'b1;
      end else if (state == S_SAMPLE && adv && tap_end) begin
        fail <= 1'b1;
      end
      if (do_step) begin
        dqs_delay <= step_down ? dqs_delay - 1'b1 : dqs_delay + 1'b1;
      end
    end
  end

  // leveling window and elapsed time helpers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wl_on <= 1'b0;
      since_mrs <= 16'hffff;
      since_odt <= 16'h0000;
    end else begin
      if (cmd.ras_n == 1'b0 && ck == 1'b0) begin
        since_mrs <= 16'h0000;
        wl_on <= (cmd.cs_n != CS_IDLE) && cmd.addr[MR1_WL_BIT] && state == S_ENTER;
      end else if (since_mrs != 16'hffff) begin
        since_mrs <= since_mrs + 16'h0001;
      end
      since_odt <= odt ? ((since_odt == 16'hffff) ? since_odt : since_odt + 16'h0001) : 16'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks on the pin sequence
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  AST_ODT_AFTER_MOD: assert property ($rose(odt) |-> since_mrs >= 16'(MOD_C))
    else $error("odt raised before mode update delay");
  AST_DQS_AFTER_ODT: assert property ($rose(dqs_oe) |-> odt && since_odt >= 16'(WLDQSEN_C))
    else $error("strobe driven too soon after odt");
  AST_ENTRY_BIT: assert property (state == S_ENTER && $fell(cmd.ras_n) |-> cmd.addr[MR1_WL_BIT])
    else $error("entry write lacks leveling enable");
  AST_OTHERS_OFF: assert property ($fell(cmd.ras_n) && state == S_OTHERS
                                   |-> cmd.addr[MR1_QOFF_BIT] && !cmd.addr[MR1_WL_BIT])
    else $error("other ranks not switched off");
  AST_ONLY_MR1: assert property (wl_on && !cmd.ras_n |-> cmd.ba == 3'(MR1_BA) && !cmd.we_n)
    else $error("illegal command in leveling");
  AST_EXIT_ORDER: assert property ($fell(cmd.ras_n) && state == S_EXIT
                                   |-> !odt && !dqs_oe && !cmd.addr[MR1_WL_BIT])
    else $error("exit write out of order");
  AST_ODT_LOW_HELD: assert property ($fell(odt) |-> !odt[*4])
    else $error("odt not held low on exit");
  AST_LOCK_EDGE: assert property (do_lock |=> locked && $stable(dqs_delay) ##1 state == S_STOP)
    else $error("lock without proper follow up");
  AST_DONE_DELAY: assert property ($rose(done) |-> since_mrs >= 16'(MOD_C))
    else $error("done before mode update delay");
  AST_PULSE: assert property ($rose(dqs) |-> dqs_oe ##1 dqs ##[1:300] $fell(dqs))
    else $error("strobe pulse malformed");

  COV_LOCK: cover property (do_lock);
  COV_STEP: cover property (do_step ##[1:1000] do_lock);
  COV_FAIL: cover property ($rose(fail));
  COV_DONE: cover property ($rose(done) && locked);
endmodule
`default_nettype wire

/* wl_dram_model.sv */
// behavioural memory rank answering write leveling
`timescale 1ns/1ps
`default_nettype none
module wl_dram_model import wl_pkg::*; #(
  parameter real MOD_NS = 49.0,
  parameter real EN_NS = 49.0,
  parameter real PRE_NS = 49.0,
  parameter real OFF_NS = 49.0
) (
  input wire logic ck,
  input wire cmd_t cmd,
  input wire logic odt,
  input wire logic dqs,
  input wire logic dqs_oe,
  input wire logic [5:0] tap,
  input wire logic [1:0] rank,
  input wire logic stuck,
  output logic [7:0] dq,
  output logic lvl = 1'b0,
  output logic [15:0] mr1 = 16'h0000,
  output logic [15:0] ent_mr1 = 16'h0000,
  output logic [1:0] smp = 2'h0,
  output logic [5:0] smp_tap = 6'h00,
  output int viol = 0,
  output real t_exit = 0.0
);
  real t_ent = 0.0;
  real t_odt = 0.0;
  real t_oe = 0.0;
  real t_off = 0.0;
  logic dly = 1'b0;
  logic fb = 1'b0;
  logic fb_ok = 1'b0;
  logic term = 1'b0;
  logic [7:0] junk = 8'h5a;
  logic [2:0] op;
  assign op = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  // commands sampled on rising ck
  always @(posedge ck) begin
    if (!cmd.cs_n[rank] && op != 3'h7) begin
      if (op != 3'h0 || cmd.ba != 3'(MR1_BA)) begin
        if (lvl) viol++;
      end else if (cmd.addr[MR1_WL_BIT]) begin
        t_ent = $realtime;
        ent_mr1 = cmd.addr;
        fb_ok = 1'b0;
        lvl = 1'b1;
      end else if (lvl) begin
        if (odt || term || $realtime < t_off + OFF_NS) viol++;
        lvl = 1'b0;
        t_exit = $realtime;
      end
      mr1 = cmd.addr;
    end else if (cmd.cs_n != CS_IDLE && op == 3'h0 && !cmd.addr[MR1_QOFF_BIT]) begin
      viol++;
    end
  end
  // only the strobe pair follows odt while leveling
  always @(odt) begin
    if (lvl && odt && $realtime < t_ent + MOD_NS) viol++;
    if (!odt && dqs_oe) viol++;
    term = lvl && odt;
    if (odt) t_odt = $realtime;
    else t_off = $realtime;
  end
  // strobe drive needs termination in place
  always @(posedge dqs_oe) begin
    if (!term || $realtime < t_odt + EN_NS) viol++;
    t_oe = $realtime;
  end
  // external delay element, one ns a tap
  always @(dqs) dly <= #(real'(tap) + 0.3) dqs;
  // ck captured on the delayed rising strobe
  always @(posedge dly) begin
    if (lvl && term) begin
      if (!fb_ok && $realtime < t_oe + PRE_NS) viol++;
      smp = {smp[0], ck & !stuck};
      smp_tap = tap;
      fb <= #(T_WLO_NS) smp[0];
      fb_ok <= #(T_WLO_NS) 1'b1;
    end
  end
  // undefined lines show a pattern that keeps moving
  always @(ck) junk = ~junk;
  assign dq = (lvl && fb_ok) ? {7'h00, fb} : junk;
endmodule
`default_nettype wire

/* wl_pkg.sv */
// constants, types and behaviour notes for the write leveling sequencer
// Notes on behaviour
// - output buffer on allows only termination values RZQ/2, RZQ/4 or RZQ/6.
// - MR1 bit 7 set enters leveling; clearing it again leaves leveling.
// - during leveling issue only NOP, deselect, or MR1 writes touching A12 or A7.
// - the exit MR1 write may also update A12-A11, A9, A6-A5 and A2-A1.
// - level one rank; other ranks get MR1 A12 set to switch outputs off.
// - assert ODT only after the mode update delay following entry.
// - drive strobe low only after the strobe enable delay following ODT.
// - after strobe low time and leveling delay send one rising strobe edge.
// - sample feedback, step delay, pulse again; lock on a 0 to 1 change.
// - exit first stops driving the strobe pair after the last rising edge.
// - next, drive ODT low and keep it low.
// - once termination is off, issue MR1 write clearing leveling enable.
// - any command only after mode update delay; MR writes after MRS-to-MRS delay.
// - MR1 A12 zero enables outputs, one disables; A7 one enables leveling.
package wl_pkg;
  localparam int CLK_NS = 25;
  // timing figures in ns, plain defaults
  localparam int T_MOD_NS = 300;
  localparam int T_MRD_NS = 100;
  localparam int T_WLDQSEN_NS = 625;
  localparam int T_WLMRD_NS = 1000;
  localparam int T_DQSL_NS = 50;
  localparam int T_DQSH_NS = 50;
  localparam int T_WLO_NS = 25;
  localparam int T_GAP_NS = 200;
  localparam int T_ODT_OFF_NS = 200;
  // least times rounded up to clock cycles
  localparam int MOD_CYC = (T_MOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int MRD_CYC = (T_MRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLDQSEN_CYC = (T_WLDQSEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WLMRD_CYC = (T_WLMRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int DQSL_CYC = (T_DQSL_NS + CLK_NS - 1) / CLK_NS;
  localparam int DQSH_CYC = (T_DQSH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_CYC = 3;
  localparam int WLO_CYC = (T_WLO_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
  localparam int GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ODT_OFF_CYC = (T_ODT_OFF_NS + CLK_NS - 1) / CLK_NS;
  // mode register 1 field positions
  localparam int MR1_BA = 1;
  localparam int MR1_WL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam logic [15:0] MR1_EXIT_MASK = 16'h1a66; // A12-A11, A9, A6-A5, A2-A1
  localparam logic [3:0] CS_IDLE = 4'hf;
  // command bus carrier
  typedef struct packed {
    logic [3:0] cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [15:0] addr;
  } cmd_t;
  localparam cmd_t CMD_NOP = '{cs_n: 4'hf, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                ba: 3'h0, addr: 16'h0000};
  typedef enum {
    S_IDLE, S_OTHERS, S_ENTER, S_ODT_ON, S_PRE, S_HIGH, S_LOW, S_SAMPLE,
    S_STOP, S_ODT_OFF, S_EXIT, S_SETTLE
  } wl_state_t;
endpackage

/* wl_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module wl_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule
`default_nettype wire
